// File: aac_pkg.sv
package aac_pkg;

	// register indices on the management port
	localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
	localparam logic [4:0] ADDR_ABILITY_ADV = 5'h04;
	localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
	localparam logic [4:0] ADDR_NEG_EXPANSION = 5'h06;
	localparam logic [4:0] ADDR_LINK_SUMMARY = 5'h10;
	localparam logic [4:0] ADDR_XCVR_CONTROL = 5'h19;

	// basic_control fields
	localparam int BC_SPEED100 = 13;
	localparam int BC_NEG_EN = 12;
	localparam int BC_RESTART = 9;
	localparam int BC_FULL = 8;

	// basic_status value: fixed ability bits, preamble suppression,
	// negotiation ability, extended capability; live bits merged in
	localparam logic [15:0] BS_FIXED = 16'h7849;
	localparam int BS_NEG_DONE = 5;
	localparam int BS_REMOTE_FAULT = 4;
	localparam int BS_LINK = 2;

	// ability advertisement / partner ability fields
	localparam int ADV_LSB = 5;
	localparam int PAGE_NEXT = 15;
	localparam int PAGE_REMOTE_FAULT = 13;
	localparam logic [4:0] SELECTOR_8023 = 5'h01;
	localparam logic [15:0] PD_WORD_100 = 16'h0081;
	localparam logic [15:0] PD_WORD_10 = 16'h0021;

	// negotiation_expansion fields
	localparam int NE_PD_FAULT = 4;
	localparam int NE_LP_NEXT = 3;
	localparam int NE_PAGE_RX = 1;
	localparam int NE_LP_ABLE = 0;

	// link_state_summary fields
	localparam int LS_NEG_DONE = 4;
	localparam int LS_FULL = 2;
	localparam int LS_SPEED10 = 1;
	localparam int LS_LINK = 0;

	// transceiver_control fields
	localparam int XC_AUTO_XOVER = 15;
	localparam int XC_FORCE_XOVER = 14;

	// timing
	localparam int CLK_KHZ = 250000;
	localparam int BREAK_LINK_MS = 1500;
	localparam int NEG_LIMIT_MS = 3000;
	localparam int XOVER_SLOT_MS = 62;
	localparam int BREAK_LINK_CYC = BREAK_LINK_MS * CLK_KHZ;
	localparam int NEG_LIMIT_CYC = NEG_LIMIT_MS * CLK_KHZ;
	localparam int XOVER_SLOT_CYC = XOVER_SLOT_MS * CLK_KHZ;
	localparam logic [3:0] STRAP_SETTLE = 4'h6;
	localparam logic [7:0] LFSR_SEED = 8'ha5;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_FORCED,
		ST_BREAK,
		ST_ABILITY,
		ST_COMPLETE
	} aac_state_type;

	// management access, one request per cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} aac_regreq_type;

	// page from the pulse receiver, valid for one cycle
	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} aac_page_type;

	// pin inputs: straps and receiver link indications
	typedef struct packed {
		logic neg_en;
		logic mode_hi;
		logic mode_lo;
		logic auto_xover;
		logic link100;
		logic link10;
	} aac_pins_type;

	// resolved technology
	typedef struct packed {
		logic ok;
		logic speed100;
		logic full;
	} aac_tech_type;

	typedef struct packed {
		aac_state_type st;
		aac_pins_type s1;
		aac_pins_type s2;
		aac_pins_type s3;
		aac_pins_type pin;
		logic [3:0] init_cnt;
		logic [31:0] cnt;
		logic [31:0] xcnt;
		logic [7:0] lfsr;
		logic [15:0] bc;
		logic [3:0] adv;
		logic [15:0] lpar;
		logic auto_xover;
		logic force_xover;
		logic armed;
		logic neg_on_q;
		logic got_page;
		logic pd_fault;
		logic page_rx;
		logic lp_able;
		logic lp_next;
		logic xover_sel;
		logic link_up;
		logic speed100;
		logic full;
		logic flp_en;
		logic tx_halt;
		logic mdix;
		logic [15:0] rdata;
	} aac_regs_type;

endpackage

// File: aac_autoneg.sv
`timescale 1ns/1ps
// Behaviour
// - straps sampled after reset set advertisement ability bits 8:5
// - negotiation strap low: mode straps force speed and duplex
// - negotiation strap high: mode straps choose advertised ability set
// - software may override strap behaviour via basic_control writes
// - while negotiating, advertisement word is sent; any bit mix allowed
// - resolve 100 full, 100 half, 10 full, 10 half in that order
// - speed and duplex bits apply only with negotiation off
// - resolved speed shown in link_state_summary once link is up
// - basic_status: fixed abilities, no T4, done, fault, link, preamble
// - advertisement defaults to all, or to the strap-chosen set when negotiating; clearing bits withholds abilities
// - partner_ability captures pages, or 0081h/0021h after detection
// - expansion flags fault, partner next page, own, page, partner able
// - a lone valid 10 or 100 link from a plain partner is adopted
// - detection sets bit 5 or 7 plus selector; partner-able reads zero
// - parallel detection flags a fault when both links are good at once
// - writing one to restart bit 9 restarts negotiation
// - loss of a negotiated link resumes negotiation
// - renegotiation silences transmit for 1500 ms, then sends bursts
// - negotiation gives up and restarts after about 3 seconds
// - auto crossover by strap or bit 15, random, never in forced mode
// - bit 14 forces crossover regardless of other settings
// - basic_status bit 6 reads one for preamble suppression
module aac_autoneg #(
	parameter int unsigned BREAK_CYCLES = aac_pkg::BREAK_LINK_CYC,
	parameter int unsigned NEG_CYCLES = aac_pkg::NEG_LIMIT_CYC,
	parameter int unsigned XOVER_CYCLES = aac_pkg::XOVER_SLOT_CYC
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire aac_pkg::aac_pins_type pins_i,
	input wire aac_pkg::aac_regreq_type req_i,
	input wire aac_pkg::aac_page_type page_i,
	output logic [15:0] reg_rdata_o,
	output logic [15:0] adv_word_o,
	output logic flp_en_o,
	output logic tx_halt_o,
	output logic link_up_o,
	output logic speed100_o,
	output logic full_duplex_o,
	output logic mdix_o
);

	// priority resolution over a four bit ability set (100F,100H,10F,10H)
	function automatic aac_pkg::aac_tech_type resolve(input logic [3:0] a);
		aac_pkg::aac_tech_type t;
		t = '{ok: 1'b1, speed100: 1'b1, full: 1'b1};
		if (a[3])
			t = '{ok: 1'b1, speed100: 1'b1, full: 1'b1};
		else if (a[2])
			t = '{ok: 1'b1, speed100: 1'b1, full: 1'b0};
		else if (a[1])
			t = '{ok: 1'b1, speed100: 1'b0, full: 1'b1};
		else if (a[0])
			t = '{ok: 1'b1, speed100: 1'b0, full: 1'b0};
		else
			t = '{ok: 1'b0, speed100: 1'b0, full: 1'b0};
		return t;
	endfunction

	// ability set selected by the mode straps when negotiating
	function automatic logic [3:0] strap_adv(input logic [1:0] m);
		logic [3:0] a;
		a = 4'hf;
		unique case (m)
			2'b00: a = 4'h3;
			2'b01: a = 4'hc;
			2'b10: a = 4'h5;
			2'b11: a = 4'hf;
		endcase
		return a;
	endfunction

	logic [1:0] rst_sync_r;
	logic rst_n;
	aac_pkg::aac_regs_type r_r;
	aac_pkg::aac_regs_type r_nxt;
	aac_pkg::aac_tech_type res;
	logic neg_on;
	logic restart;
	logic link_ok;
	logic bc_wr;
	logic [15:0] bs_word;
	logic [15:0] ne_word;
	logic [15:0] ls_word;
	logic [15:0] adv_word;

	// reset release passes two flops; assertion stays asynchronous
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// read views of the live registers
	always_comb
	begin
		adv_word = {7'h00, r_r.adv, aac_pkg::SELECTOR_8023};
		bs_word = aac_pkg::BS_FIXED;
		bs_word[aac_pkg::BS_NEG_DONE] = (r_r.st == aac_pkg::ST_COMPLETE);
		bs_word[aac_pkg::BS_REMOTE_FAULT] =
			r_r.lpar[aac_pkg::PAGE_REMOTE_FAULT] & r_r.got_page;
		bs_word[aac_pkg::BS_LINK] = r_r.link_up;
		ne_word = 16'h0000;
		ne_word[aac_pkg::NE_PD_FAULT] = r_r.pd_fault;
		ne_word[aac_pkg::NE_LP_NEXT] = r_r.lp_next;
		ne_word[aac_pkg::NE_PAGE_RX] = r_r.page_rx;
		ne_word[aac_pkg::NE_LP_ABLE] = r_r.lp_able;
		ls_word = 16'h0000;
		ls_word[aac_pkg::LS_NEG_DONE] = (r_r.st == aac_pkg::ST_COMPLETE);
		ls_word[aac_pkg::LS_FULL] = r_r.link_up & r_r.full;
		ls_word[aac_pkg::LS_SPEED10] = r_r.link_up & ~r_r.speed100;
		ls_word[aac_pkg::LS_LINK] = r_r.link_up;
	end

	// next state of the whole block
	always_comb
	begin
		r_nxt = r_r;
		bc_wr = req_i.wr && (req_i.addr == aac_pkg::ADDR_BASIC_CONTROL);
		res = resolve(r_r.adv & r_r.lpar[8:5]);
		link_ok = r_r.speed100 ? r_r.pin.link100 : r_r.pin.link10;

		// pin inputs: three flops, a change counts once two and three agree
		r_nxt.s1 = pins_i;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		if (r_r.s2 == r_r.s3)
			r_nxt.pin = r_r.s3;

		// management writes; the restart bit never stores
		if (bc_wr && r_r.st != aac_pkg::ST_INIT)
		begin
			r_nxt.bc = req_i.wdata;
			r_nxt.bc[aac_pkg::BC_RESTART] = 1'b0;
			if (!req_i.wdata[aac_pkg::BC_NEG_EN])
				r_nxt.armed = 1'b1;
		end
		if (req_i.wr && req_i.addr == aac_pkg::ADDR_ABILITY_ADV)
			r_nxt.adv = req_i.wdata[8:5];
		if (req_i.wr && req_i.addr == aac_pkg::ADDR_XCVR_CONTROL)
		begin
			r_nxt.auto_xover = req_i.wdata[aac_pkg::XC_AUTO_XOVER];
			r_nxt.force_xover = req_i.wdata[aac_pkg::XC_FORCE_XOVER];
		end

		// reads; expansion event flags clear on read, a new event wins
		if (req_i.rd)
		begin
			unique case (req_i.addr)
				aac_pkg::ADDR_BASIC_CONTROL: r_nxt.rdata = r_r.bc;
				aac_pkg::ADDR_BASIC_STATUS: r_nxt.rdata = bs_word;
				aac_pkg::ADDR_ABILITY_ADV: r_nxt.rdata = adv_word;
				aac_pkg::ADDR_PARTNER_ABILITY: r_nxt.rdata = r_r.lpar;
				aac_pkg::ADDR_NEG_EXPANSION: r_nxt.rdata = ne_word;
				aac_pkg::ADDR_LINK_SUMMARY: r_nxt.rdata = ls_word;
				aac_pkg::ADDR_XCVR_CONTROL: r_nxt.rdata =
					{r_r.auto_xover, r_r.force_xover, 14'h0000};
				default: r_nxt.rdata = 16'h0000;
			endcase
			if (req_i.addr == aac_pkg::ADDR_NEG_EXPANSION)
			begin
				r_nxt.pd_fault = 1'b0;
				r_nxt.page_rx = 1'b0;
			end
		end

		// an enable only counts once armed after forced straps
		neg_on = r_nxt.bc[aac_pkg::BC_NEG_EN] & r_nxt.armed;
		r_nxt.neg_on_q = neg_on;
		restart = (neg_on && !r_r.neg_on_q) ||
			(bc_wr && req_i.wdata[aac_pkg::BC_RESTART] && neg_on);

		r_nxt.cnt = r_r.cnt + 32'h1;
		unique case (r_r.st)
			aac_pkg::ST_INIT:
			begin
				// hold until synchronised straps settle, then latch them
				r_nxt.init_cnt = r_r.init_cnt + 4'h1;
				if (r_r.init_cnt == aac_pkg::STRAP_SETTLE)
				begin
					r_nxt.bc = 16'h0000;
					r_nxt.bc[aac_pkg::BC_NEG_EN] = r_r.pin.neg_en;
					r_nxt.bc[aac_pkg::BC_SPEED100] = r_r.pin.mode_hi;
					r_nxt.bc[aac_pkg::BC_FULL] = r_r.pin.mode_lo;
					r_nxt.adv = r_r.pin.neg_en ?
						strap_adv({r_r.pin.mode_hi, r_r.pin.mode_lo}) :
						4'hf;
					r_nxt.armed = r_r.pin.neg_en;
					r_nxt.neg_on_q = r_r.pin.neg_en; // no break at power-up
					r_nxt.auto_xover = r_r.pin.auto_xover;
					r_nxt.cnt = 32'h0;
					r_nxt.st = r_r.pin.neg_en ? aac_pkg::ST_ABILITY :
						aac_pkg::ST_FORCED;
				end
			end
			aac_pkg::ST_FORCED:
			begin
				// operating mode straight from the control bits
				r_nxt.speed100 = r_r.bc[aac_pkg::BC_SPEED100];
				r_nxt.full = r_r.bc[aac_pkg::BC_FULL];
				r_nxt.link_up = link_ok;
			end
			aac_pkg::ST_BREAK:
			begin
				// silence so the partner drops its link too
				if (r_r.cnt >= 32'(BREAK_CYCLES - 1))
				begin
					r_nxt.cnt = 32'h0;
					r_nxt.st = aac_pkg::ST_ABILITY;
				end
			end
			aac_pkg::ST_ABILITY:
			begin
				if (page_i.valid)
				begin
					r_nxt.lpar = page_i.word;
					r_nxt.got_page = 1'b1;
					r_nxt.lp_able = 1'b1;
					r_nxt.page_rx = 1'b1;
					r_nxt.lp_next = page_i.word[aac_pkg::PAGE_NEXT];
				end
				if (r_r.got_page)
				begin
					// negotiated: wait for the chosen receiver to see link
					if (res.ok && (res.speed100 ? r_r.pin.link100 :
						r_r.pin.link10))
					begin
						r_nxt.speed100 = res.speed100;
						r_nxt.full = res.full;
						r_nxt.st = aac_pkg::ST_COMPLETE;
					end
				end
				else if (r_r.pin.link10 && r_r.pin.link100)
					r_nxt.pd_fault = 1'b1;
				else if (r_r.pin.link10 ^ r_r.pin.link100)
				begin
					// plain partner: adopt the one valid link, half duplex
					r_nxt.lpar = r_r.pin.link100 ? aac_pkg::PD_WORD_100 :
						aac_pkg::PD_WORD_10;
					r_nxt.lp_able = 1'b0;
					r_nxt.speed100 = r_r.pin.link100;
					r_nxt.full = 1'b0;
					r_nxt.st = aac_pkg::ST_COMPLETE;
				end
				// a hung exchange restarts rather than waiting forever
				if (r_r.cnt >= 32'(NEG_CYCLES - 1) &&
					r_nxt.st == aac_pkg::ST_ABILITY)
				begin
					r_nxt.cnt = 32'h0;
					r_nxt.got_page = 1'b0;
					r_nxt.st = aac_pkg::ST_BREAK;
				end
			end
			aac_pkg::ST_COMPLETE:
			begin
				r_nxt.link_up = link_ok;
				if (!link_ok)
				begin
					r_nxt.cnt = 32'h0;
					r_nxt.got_page = 1'b0;
					r_nxt.st = aac_pkg::ST_BREAK;
				end
			end
			default: r_nxt.st = aac_pkg::ST_INIT;
		endcase

		// control changes override the sequence above
		if (r_r.st != aac_pkg::ST_INIT)
		begin
			if (!neg_on)
				r_nxt.st = aac_pkg::ST_FORCED;
			else if (restart)
			begin
				r_nxt.cnt = 32'h0;
				r_nxt.got_page = 1'b0;
				r_nxt.st = aac_pkg::ST_BREAK;
			end
		end
		if (r_nxt.st != aac_pkg::ST_COMPLETE &&
			r_nxt.st != aac_pkg::ST_FORCED)
			r_nxt.link_up = 1'b0;

		// crossover hunt: random flips per slot while seeking a link
		r_nxt.xcnt = r_r.xcnt + 32'h1;
		if (r_r.xcnt >= 32'(XOVER_CYCLES - 1))
		begin
			r_nxt.xcnt = 32'h0;
			r_nxt.lfsr = {r_r.lfsr[6:0],
				r_r.lfsr[7] ^ r_r.lfsr[5] ^ r_r.lfsr[4] ^ r_r.lfsr[3]};
			if ((r_r.st == aac_pkg::ST_ABILITY ||
				r_r.st == aac_pkg::ST_BREAK) && r_r.lfsr[0])
				r_nxt.xover_sel = ~r_r.xover_sel;
		end
		// never automatic in forced operation; bit 14 always wins
		if (!r_r.auto_xover || r_r.st == aac_pkg::ST_FORCED)
			r_nxt.xover_sel = 1'b0;
		r_nxt.mdix = r_nxt.force_xover | r_nxt.xover_sel;

		r_nxt.flp_en = (r_nxt.st == aac_pkg::ST_ABILITY);
		r_nxt.tx_halt = (r_nxt.st == aac_pkg::ST_BREAK);
	end

	// single register for all block state except the reset synchroniser
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_r <= '0;
			r_r.st <= aac_pkg::ST_INIT;
			r_r.lfsr <= aac_pkg::LFSR_SEED;
			r_r.adv <= 4'hf;
		end
		else
			r_r <= r_nxt;
	end

	assign reg_rdata_o = r_r.rdata;
	assign adv_word_o = {7'h00, r_r.adv, aac_pkg::SELECTOR_8023};
	assign flp_en_o = r_r.flp_en;
	assign tx_halt_o = r_r.tx_halt;
	assign link_up_o = r_r.link_up;
	assign speed100_o = r_r.speed100;
	assign full_duplex_o = r_r.full;
	assign mdix_o = r_r.mdix;

endmodule

// File: aac_autoneg_properties.sv
`timescale 1ns/1ps
module aac_autoneg_props #(
	parameter int unsigned BREAK_CYCLES = aac_pkg::BREAK_LINK_CYC
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire aac_pkg::aac_regreq_type req_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [15:0] adv_word_o,
	input wire logic flp_en_o,
	input wire logic tx_halt_o,
	input wire logic link_up_o,
	input wire logic speed100_o,
	input wire logic full_duplex_o,
	input wire logic mdix_o
);
	logic [31:0] halt_r;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	// silent cycles so far; a counter keeps the long interval cheap
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			halt_r <= 32'h0;
		else
			halt_r <= tx_halt_o ? halt_r + 32'h1 : 32'h0;
	end
	// break interval and what follows it
	chk_break_len: assert property ($fell(tx_halt_o) |->
		halt_r >= BREAK_CYCLES && halt_r <= BREAK_CYCLES + 1)
		else $error("break interval length wrong");
	chk_halt_quiet: assert property (tx_halt_o |-> !flp_en_o)
		else $error("bursts during break interval");
	chk_break_resume: assert property (
		$fell(tx_halt_o) |-> ##[0:1] flp_en_o)
		else $error("no bursts after break interval");
	chk_adv_frame: assert property (
		adv_word_o[15:9] == 7'h0 && adv_word_o[4:0] == 5'h01)
		else $error("advertised word framing wrong");
	// register reads, answered one cycle later
	chk_status_fixed: assert property (
		req_i.rd && req_i.addr == 5'h01 |=>
		(reg_rdata_o & 16'hffcb) == 16'h7849)
		else $error("fixed status bits wrong");
	chk_unmapped_zero: assert property (
		req_i.rd && !(req_i.addr inside {5'h00, 5'h01, 5'h04, 5'h05,
		5'h06, 5'h10, 5'h19}) |=> reg_rdata_o == 16'h0)
		else $error("unmapped read not zero");
	chk_summary_link: assert property (
		req_i.rd && req_i.addr == 5'h10 && link_up_o |=>
		reg_rdata_o[2:0] == {$past(full_duplex_o), !$past(speed100_o), 1'b1})
		else $error("link summary disagrees with mode");
	chk_force_xover: assert property (
		req_i.rd && req_i.addr == 5'h19 ##1 reg_rdata_o[14] |-> mdix_o)
		else $error("forced crossover not applied");
	// main scenarios
	cov_link: cover property ($rose(link_up_o));
	cov_break: cover property ($fell(tx_halt_o));
	cov_xover: cover property ($rose(mdix_o));
endmodule

bind aac_autoneg aac_autoneg_props #(.BREAK_CYCLES(BREAK_CYCLES)) chk_u (
	.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i),
	.reg_rdata_o(reg_rdata_o), .adv_word_o(adv_word_o),
	.flp_en_o(flp_en_o), .tx_halt_o(tx_halt_o), .link_up_o(link_up_o),
	.speed100_o(speed100_o), .full_duplex_o(full_duplex_o),
	.mdix_o(mdix_o)
);

// File: aac_partner.sv
`timescale 1ns/1ps
module aac_partner (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic flp_en_i,
	input wire logic tx_halt_i,
	input wire logic [15:0] adv_word_i,
	input wire logic neg_i,
	input wire logic [15:0] word_i,
	input wire logic plain100_i,
	input wire logic plain10_i,
	input wire logic cable_i,
	output logic link100_o,
	output logic link10_o,
	output aac_pkg::aac_page_type page_o
);
	logic [3:0] com;
	logic [2:0] age_r;
	logic up_r;
	// abilities both ends share
	assign com = word_i[8:5] & adv_word_i[8:5];
	// one page a few cycles into each burst phase; link follows it
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			age_r <= 3'h0;
			up_r <= 1'b0;
			page_o <= '0;
		end
		else
		begin
			age_r <= !flp_en_i ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
			page_o.valid <= neg_i && cable_i && age_r == 3'h5;
			// idle word lines alternate between the inverse of the last page and the page itself
			page_o.word <= age_r == 3'h5 ? word_i : ~page_o.word;
			if (tx_halt_i || !cable_i)
				up_r <= 1'b0;
			else if (page_o.valid)
				up_r <= 1'b1;
		end
	end
	// best common technology first; plain partners show link whenever the cable is in
	assign link100_o = cable_i && (plain100_i || up_r && |com[3:2]);
	assign link10_o = cable_i && (plain10_i ||
		up_r && com[3:2] == 2'h0 && |com[1:0]);
endmodule

// File: aac_autoneg_tb.sv
`timescale 1ns/1ps
module aac_autoneg_tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic s_neg, s_hi, s_lo, s_ax, p_neg, p100, p10, p_cab;
	logic l100, l10, flp, halt, link, sp, fd, mdix;
	logic [15:0] p_word, rv, rdata, adv;
	aac_pkg::aac_pins_type pins;
	aac_pkg::aac_regreq_type req;
	aac_pkg::aac_page_type page;
	int err_count, n_tests;
	// crossover strap normally on; one scenario turns it off
	assign pins = {s_neg, s_hi, s_lo, s_ax, l100, l10};
	always #2 clk_i = ~clk_i;
	aac_autoneg #(.BREAK_CYCLES(20), .NEG_CYCLES(200),
		.XOVER_CYCLES(8)) dut_u (
		.clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins), .req_i(req),
		.page_i(page), .reg_rdata_o(rdata), .adv_word_o(adv),
		.flp_en_o(flp), .tx_halt_o(halt), .link_up_o(link),
		.speed100_o(sp), .full_duplex_o(fd), .mdix_o(mdix));
	aac_partner peer_u (
		.clk_i(clk_i), .rstn_i(rstn_i), .flp_en_i(flp), .tx_halt_i(halt),
		.adv_word_i(adv), .neg_i(p_neg), .word_i(p_word),
		.plain100_i(p100), .plain10_i(p10), .cable_i(p_cab),
		.link100_o(l100), .link10_o(l10), .page_o(page));
	task check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task check1(input string what, input logic seen, input logic exp);
		check(what, {15'h0, seen}, {15'h0, exp});
	endtask
	task wrap_up;
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_i);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge clk_i);
		req.wr = 1'b0;
	endtask
	task rdc(input string w, input logic [4:0] a, input logic [15:0] m,
		input logic [15:0] e);
		@(negedge clk_i);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk_i);
		req.rd = 1'b0;
		@(negedge clk_i);
		rv = rdata;
		check(w, rv & m, e);
	endtask
	// bounded wait on link, bursts, break or speed
	task waits(input int sel, input logic v, input int bound);
		logic s;
		repeat (bound)
		begin
			@(negedge clk_i);
			s = sel == 0 ? link : sel == 1 ? flp : sel == 2 ? halt : sp;
			if (s === v)
				return;
		end
		err_count++;
		wrap_up();
	endtask
	task boot(input logic n, input logic [1:0] m);
		rstn_i = 1'b0;
		{s_neg, s_hi, s_lo} = {n, m};
		cyc(10);
		rstn_i = 1'b1;
		cyc(14);
	endtask
	task t_forced;
		logic [1:0] m;
		for (int i = 0; i < 4; i++)
		begin
			m = 2'(i);
			{p_neg, p100, p10, p_cab} = {1'b0, m[1], !m[1], 1'b1};
			boot(1'b0, m);
			waits(0, 1'b1, 40);
			check1("speed", sp, m[1]);
			check1("duplex", fd, m[0]);
			rdc("control", 5'h00, 16'h2300,
				{2'h0, m[1], 4'h0, m[0], 8'h0});
			check("adv", adv, 16'h01e1);
			check1("mdix", mdix, 1'b0);
		end
	endtask
	task t_neg;
		logic [1:0] m;
		logic [3:0] ab [4];
		ab = '{4'h3, 4'hc, 4'h5, 4'hf};
		for (int i = 0; i < 4; i++)
		begin
			m = 2'(i);
			{p_neg, p100, p10, p_cab} = 4'b1001;
			p_word = 16'h01e1;
			boot(1'b1, m);
			check("adv", adv, {7'h0, ab[i], 5'h01});
			rdc("adv reg", 5'h04, 16'hffff, {7'h0, ab[i], 5'h01});
			waits(0, 1'b1, 100);
			check1("speed", sp, m != 2'h0);
			check1("duplex", fd, m != 2'h2);
			rdc("partner", 5'h05, 16'hffff, 16'h01e1);
			rdc("status", 5'h01, 16'h0034, 16'h0024);
			rdc("summary", 5'h10, 16'h0017,
				{12'h001, 1'b0, fd, !sp, 1'b1});
			rdc("expansion", 5'h06, 16'h001f, 16'h0003);
		end
	endtask
	task t_pd;
		{p_neg, p100, p10, p_cab} = 4'b0101;
		boot(1'b0, 2'h0);
		wr(5'h00, 16'h1000);
		cyc(6);
		check1("unarmed", flp | halt, 1'b0);
		wr(5'h00, 16'h2100);
		waits(3, 1'b1, 10);
		check1("duplex", fd, 1'b1);
		wr(5'h00, 16'h1000);
		waits(2, 1'b1, 10);
		check1("silent", flp, 1'b0);
		waits(1, 1'b1, 40);
		waits(0, 1'b1, 60);
		check1("speed", sp, 1'b1);
		check1("duplex", fd, 1'b0);
		rdc("partner", 5'h05, 16'hffff, 16'h0081);
		rdc("expansion", 5'h06, 16'h0011, 16'h0000);
		wr(5'h00, 16'h1200);
		{p100, p10} = 2'b01;
		waits(2, 1'b1, 10);
		waits(0, 1'b1, 100);
		check1("speed", sp, 1'b0);
		rdc("partner", 5'h05, 16'hffff, 16'h0021);
		rdc("control", 5'h00, 16'h0200, 16'h0000);
		wr(5'h00, 16'h1200);
		p100 = 1'b1;
		waits(1, 1'b1, 40);
		rv = 16'h0;
		for (int i = 0; i < 30 && rv[4] !== 1'b1; i++)
			rdc("poll", 5'h06, 16'h0, 16'h0);
		check1("pd fault", rv[4], 1'b1);
		check1("no link", link, 1'b0);
	endtask
	task t_loss;
		{p_neg, p100, p10, p_cab} = 4'b1001;
		// partner also flags next page and remote fault
		p_word = 16'ha061;
		boot(1'b1, 2'h3);
		waits(0, 1'b1, 100);
		check1("speed", sp, 1'b0);
		check1("duplex", fd, 1'b1);
		rdc("remote fault", 5'h01, 16'h0010, 16'h0010);
		rdc("expansion", 5'h06, 16'h000f, 16'h000b);
		rdc("exp cleared", 5'h06, 16'h0002, 16'h0000);
		wr(5'h04, 16'h0021);
		wr(5'h00, 16'h1200);
		waits(2, 1'b1, 10);
		waits(0, 1'b1, 100);
		check1("withheld", fd, 1'b0);
		p_cab = 1'b0;
		waits(2, 1'b1, 20);
		p_cab = 1'b1;
		waits(0, 1'b1, 100);
	endtask
	// pair swaps seen over a stretch of cycles
	task swaps(input int len, output int n);
		logic prev;
		n = 0;
		prev = mdix;
		repeat (len)
		begin
			@(negedge clk_i);
			n += int'(mdix !== prev);
			prev = mdix;
		end
	endtask
	task t_xover;
		int n;
		{p_neg, p100, p10, p_cab} = 4'b0000;
		boot(1'b1, 2'h3);
		// no partner: a hung exchange must fall back to a break
		waits(2, 1'b1, 220);
		swaps(300, n);
		check1("auto swaps", n != 0, 1'b1);
		wr(5'h19, 16'h0000);
		cyc(3);
		check1("auto off", mdix, 1'b0);
		wr(5'h19, 16'h4000);
		cyc(3);
		check1("forced", mdix, 1'b1);
		rdc("xcvr", 5'h19, 16'hffff, 16'h4000);
		rdc("unmapped", 5'h1f, 16'hffff, 16'h0000);
		// strap off: no hunting until software turns it on
		s_ax = 1'b0;
		boot(1'b1, 2'h3);
		swaps(300, n);
		check1("strap off", n != 0, 1'b0);
		wr(5'h19, 16'h8000);
		rdc("xcvr auto", 5'h19, 16'hffff, 16'h8000);
		swaps(300, n);
		check1("sw auto", n != 0, 1'b1);
		s_ax = 1'b1;
	endtask
	initial
	begin
		err_count = 0;
		n_tests = 0;
		req = '0;
		{s_neg, s_hi, s_lo, p_neg, p100, p10, p_cab} = 7'h0;
		s_ax = 1'b1;
		p_word = 16'h0;
		rv = 16'h0;
		t_forced();
		t_neg();
		t_pd();
		t_loss();
		t_xover();
		wrap_up();
	end
endmodule
